// ===== pkg/adc_pkg.sv
// Constants and types shared by the converter control and its result buffer.
// Assumes a 25 MHz system clock; the serial clock comes from the host.
`default_nettype none
package adc_pkg;

  localparam int RESULT_WIDTH = 18;
  localparam int MCLK_PERIOD_NS = 40;
  localparam int CONV_TIME_NS = 3000;
  localparam int CONV_CYCLES = CONV_TIME_NS / MCLK_PERIOD_NS;
  localparam int HOLD_TIME_NS = 540;
  localparam int HOLD_CYCLES = HOLD_TIME_NS / MCLK_PERIOD_NS;
  localparam int CNT_WIDTH = 7;
  localparam int BUF_DEPTH = 2;
  localparam int SYNC_PINS = 4;
  localparam int PIN_CONVERT = 0;
  localparam int PIN_CHAIN = 1;
  localparam int PIN_ENABLE = 2;
  localparam int PIN_GAIN = 3;
  localparam int SHIFT_CNT_WIDTH = 5;
  localparam logic [17:0] RESULT_RESET = 18'h00000;
  localparam logic [17:0] CODE_MAX_POS = 18'h1FFFF;
  localparam logic [17:0] CODE_MAX_NEG = 18'h20000;

  typedef enum logic [1:0] {
    ST_POWER_DOWN,
    ST_CONVERT,
    ST_DELIVER,
    ST_PUBLISH
  } conv_state_type;

endpackage : adc_pkg
`default_nettype wire

// ===== pkg/result_stream_if.sv
// Valid/ready word stream between the converter control and its buffer.
// Assumes both ends run on the system clock.
`timescale 1ns/100ps
`default_nettype none
interface result_stream_if #(
  parameter int WIDTH = 18
);
  logic [WIDTH-1:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : result_stream_if
`default_nettype wire

// ===== rtl/result_buffer.sv
// Two-entry result buffer with valid/ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module result_buffer
  import adc_pkg::*;
#(
  parameter int WIDTH = RESULT_WIDTH,
  parameter int DEPTH = BUF_DEPTH
) (
  input wire logic i_mclk,
  input wire logic i_resetn,
  result_stream_if.snk in_port,
  result_stream_if.src out_port
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] DEPTH_CNT = (PW + 1)'(DEPTH);
  localparam logic [PW-1:0] LAST_IDX = PW'(DEPTH - 1);

  logic [WIDTH-1:0] store [DEPTH];
  logic [PW-1:0] wr_idx;
  logic [PW-1:0] rd_idx;
  logic [PW:0] fill;
  wire push = in_port.valid & in_port.ready;
  wire pop = out_port.valid & out_port.ready;
  wire [PW-1:0] next_wr_idx = (wr_idx == LAST_IDX) ? '0 : wr_idx + 1'b1;
  wire [PW-1:0] next_rd_idx = (rd_idx == LAST_IDX) ? '0 : rd_idx + 1'b1;

  // Full and empty come from the fill count, never from the pointers alone
  assign in_port.ready = (fill != DEPTH_CNT);
  assign out_port.valid = (fill != '0);
  assign out_port.data = store[rd_idx];

  always_ff @(posedge i_mclk) begin
    if (push) begin
      store[wr_idx] <= in_port.data;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      wr_idx <= '0;
      rd_idx <= '0;
      fill <= '0;
    end else begin
      if (push) wr_idx <= next_wr_idx;
      if (pop) rd_idx <= next_rd_idx;
      if (push && !pop) fill <= fill + 1'b1;
      else if (pop && !push) fill <= fill - 1'b1;
    end
  end
endmodule : result_buffer
`default_nettype wire

// ===== rtl/adc_convert_readout.sv
// Conversion control and serial result readout of an 18-bit SAR converter.
// Assumes the host drives convert, serial clock and enable pins asynchronously,
// and that the serial clock toggles three times in reset and twice after release.
//
// Behaviour
// - Rising convert edge wakes the device from power-down and starts converting.
// - Busy goes high as a new conversion begins.
// - Busy returns low once conversion completes; result then available.
// - Chain select low: shared pin enables or disables the serial output.
// - Chain select high: shared pin is the serial input from another converter.
// - Enabled output shifts one bit per rising serial clock edge, MSB first.
// - Output stream carries own result, then chained data from another converter.
// - Result is coded as two's complement.
// - Gain select low: full scale maps to the 10% to 90% input span.
// - Gain select high: no scaling, full scale is the whole differential range.
// - Hold interval between acquisitions lasts at most 540 ns, then acquiring resumes.
// - At conversion end an 18-bit word is prepared for serial transfer.
// - Result read after a conversion belongs to that conversion, no latency.
`timescale 1ns/100ps
`default_nettype none
module adc_convert_readout
  import adc_pkg::*;
#(
  parameter int WIDTH = RESULT_WIDTH,
  parameter int CONV_CNT = CONV_CYCLES,
  parameter int HOLD_CNT = HOLD_CYCLES
) (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_sck,
  input wire logic i_convert_start,
  input wire logic i_chain_mode,
  input wire logic i_enable_or_chain_input,
  input wire logic i_gain_compress_select,
  input wire logic [17:0] i_sample_code,
  output logic o_busy,
  output logic o_power_down,
  output logic o_acquiring,
  output logic o_result_serial_out,
  output logic o_result_serial_oe
);
  localparam logic [CNT_WIDTH-1:0] CONV_LAST = CNT_WIDTH'(CONV_CNT - 1);
  localparam logic [CNT_WIDTH-1:0] HOLD_LAST = CNT_WIDTH'(HOLD_CNT - 1);
  localparam int HOLD_MAX = HOLD_CNT;
  localparam logic [SHIFT_CNT_WIDTH-1:0] SHIFT_SAT = '1;

  // Pin synchronisers, three stages, level taken when stages two and three agree
  logic [SYNC_PINS-1:0] sync1;
  logic [SYNC_PINS-1:0] sync2;
  logic [SYNC_PINS-1:0] sync3;
  logic [SYNC_PINS-1:0] pin_level;
  wire [SYNC_PINS-1:0] pins_raw = {i_gain_compress_select, i_enable_or_chain_input,
                                   i_chain_mode, i_convert_start};
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_PINS; gi++) begin : g_sync
      wire agree = (sync2[gi] == sync3[gi]);
      always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
          sync1[gi] <= 1'b0;
          sync2[gi] <= 1'b0;
          sync3[gi] <= 1'b0;
          pin_level[gi] <= 1'b0;
        end else begin
          sync1[gi] <= pins_raw[gi];
          sync2[gi] <= sync1[gi];
          sync3[gi] <= sync2[gi];
          if (agree) pin_level[gi] <= sync3[gi];
        end
      end
    end
  endgenerate

  wire cnv_agree = (sync2[PIN_CONVERT] == sync3[PIN_CONVERT]);
  wire cnv_rise = cnv_agree & sync3[PIN_CONVERT] & ~pin_level[PIN_CONVERT];
  wire chain_lvl = pin_level[PIN_CHAIN];
  wire enable_n_lvl = pin_level[PIN_ENABLE];
  // Strap low selects compression
  wire gain_compression_lvl = ~pin_level[PIN_GAIN];

  // Conversion sequencer
  conv_state_type state;
  conv_state_type next_state;
  logic [CNT_WIDTH-1:0] conv_cnt;
  logic [CNT_WIDTH-1:0] hold_cnt;
  logic [17:0] code_hold;
  logic gain_compression;
  logic stale;
  wire start = (state == ST_POWER_DOWN) & cnv_rise;
  wire conv_done = (state == ST_CONVERT) & (conv_cnt == CONV_LAST);

  result_stream_if #(.WIDTH(WIDTH)) conv_word ();
  result_stream_if #(.WIDTH(WIDTH)) buf_word ();

  // Transfer stage toward the serial clock domain
  logic [17:0] tx_word;
  logic tx_tog;
  logic ack1;
  logic ack2;
  wire tx_pending = (tx_tog != ack2);
  wire tx_load = buf_word.valid & buf_word.ready;

  always_comb begin
    next_state = state;
    case (state)
      ST_POWER_DOWN: if (cnv_rise) next_state = ST_CONVERT;
      ST_CONVERT: if (conv_done) next_state = ST_DELIVER;
      ST_DELIVER: if (conv_word.ready) next_state = ST_PUBLISH;
      ST_PUBLISH: if (tx_load) next_state = ST_POWER_DOWN;
      default: next_state = ST_POWER_DOWN;
    endcase
  end

  wire next_busy = (next_state != ST_POWER_DOWN);
  wire hold_active = (state == ST_CONVERT) & (hold_cnt != HOLD_LAST);
  wire next_acquiring = ~(start | hold_active);

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      state <= ST_POWER_DOWN;
      o_busy <= 1'b0;
      o_power_down <= 1'b1;
      o_acquiring <= 1'b1;
    end else begin
      state <= next_state;
      o_busy <= next_busy;
      o_power_down <= (next_state == ST_POWER_DOWN);
      o_acquiring <= next_acquiring;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      conv_cnt <= '0;
      hold_cnt <= '0;
    end else begin
      conv_cnt <= (state == ST_CONVERT) ? conv_cnt + 1'b1 : '0;
      if (start) hold_cnt <= '0;
      else if (hold_active) hold_cnt <= hold_cnt + 1'b1;
    end
  end

  // Sample and gain choice are frozen at the convert edge
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      code_hold <= RESULT_RESET;
      gain_compression <= 1'b0;
    end else if (start) begin
      code_hold <= i_sample_code;
      gain_compression <= gain_compression_lvl;
    end
  end

  // Compression widens the 10%..90% span by five quarters, clipped at the rails
  wire signed [19:0] code_wide = {{2{code_hold[17]}}, code_hold};
  wire signed [19:0] code_quarter = {{4{code_hold[17]}}, code_hold[17:2]};
  wire signed [19:0] scaled_wide = code_wide + code_quarter;
  wire scaled_fits = (scaled_wide[19:17] == 3'h0) | (scaled_wide[19:17] == 3'h7);
  wire [17:0] scaled_code = scaled_fits ? scaled_wide[17:0]
                          : (scaled_wide[19] ? CODE_MAX_NEG : CODE_MAX_POS);
  wire [17:0] result_code = gain_compression ? scaled_code : code_hold;

  assign conv_word.data = result_code;
  assign conv_word.valid = (state == ST_DELIVER);
  // Drain accepts when the last word was read, or overwrites one the host skipped
  assign buf_word.ready = ~tx_pending | stale;

  result_buffer #(
    .WIDTH(WIDTH),
    .DEPTH(BUF_DEPTH)
  ) u_buffer (
    .i_mclk(i_mclk),
    .i_resetn(i_resetn),
    .in_port(conv_word),
    .out_port(buf_word)
  );

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      stale <= 1'b0;
    end else if (start & tx_pending) begin
      stale <= 1'b1;
    end else if (tx_load) begin
      stale <= 1'b0;
    end
  end

  // Word and toggle change only while busy is high, when the host must not clock
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      tx_word <= RESULT_RESET;
      tx_tog <= 1'b0;
    end else if (tx_load) begin
      tx_word <= buf_word.data;
      if (!tx_pending) tx_tog <= ~tx_tog;
    end
  end

  // Output enable: pin gates the driver in normal mode, always on in chain mode
  wire oe_want = chain_lvl | ~enable_n_lvl;
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      o_result_serial_oe <= 1'b0;
    end else begin
      o_result_serial_oe <= oe_want;
    end
  end

  // Serial clock domain
  logic sck_rst1;
  logic sck_rstn;
  logic taken_tog;
  logic [17:0] shreg;
  logic [SHIFT_CNT_WIDTH-1:0] shift_cnt;
  // Quasi-static crossing: tx_word and tx_tog settle on the same edge that drops busy
  wire sck_load = (tx_tog != taken_tog);
  // Chained data arrives on the serial clock itself, so no resampling
  wire chain_bit = i_enable_or_chain_input;

  always_ff @(posedge i_sck) begin
    sck_rst1 <= i_resetn;
    sck_rstn <= sck_rst1;
  end

  always_ff @(posedge i_sck) begin
    if (!sck_rstn) begin
      taken_tog <= 1'b0;
      shreg <= RESULT_RESET;
      o_result_serial_out <= 1'b0;
      shift_cnt <= '0;
    end else if (sck_load) begin
      taken_tog <= tx_tog;
      o_result_serial_out <= tx_word[17];
      shreg <= {tx_word[16:0], chain_bit};
      shift_cnt <= SHIFT_CNT_WIDTH'(1);
    end else begin
      o_result_serial_out <= shreg[17];
      shreg <= {shreg[16:0], chain_bit};
      if (shift_cnt != SHIFT_SAT) shift_cnt <= shift_cnt + 1'b1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      ack1 <= 1'b0;
      ack2 <= 1'b0;
    end else begin
      ack1 <= taken_tog;
      ack2 <= ack1;
    end
  end

  // Checking helpers
  logic [CNT_WIDTH-1:0] busy_len;
  logic [17:0] last_push;
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      busy_len <= '0;
      last_push <= RESULT_RESET;
    end else begin
      busy_len <= o_busy ? ((busy_len == '1) ? busy_len : busy_len + 1'b1) : '0;
      if (conv_word.valid & conv_word.ready) last_push <= conv_word.data;
    end
  end

  // Each property names its own clock, as two domains are checked here
  property p_wake;
    @(posedge i_mclk) disable iff (!i_resetn)
    start |=> (state == ST_CONVERT) && !o_power_down;
  endproperty
  a_wake: assert property (p_wake) else $error("convert edge did not wake");

  property p_busy_rise;
    @(posedge i_mclk) disable iff (!i_resetn)
    start |=> o_busy ##1 o_busy;
  endproperty
  a_busy_rise: assert property (p_busy_rise) else $error("busy not raised");

  property p_busy_len;
    @(posedge i_mclk) disable iff (!i_resetn)
    $fell(o_busy) |-> $past(busy_len) >= CNT_WIDTH'(CONV_CNT);
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy fell early");

  property p_busy_ends;
    @(posedge i_mclk) disable iff (!i_resetn)
    $rose(o_busy) |-> ##[1:90] !o_busy;
  endproperty
  a_busy_ends: assert property (p_busy_ends) else $error("busy stuck high");

  property p_hold;
    @(posedge i_mclk) disable iff (!i_resetn)
    $fell(o_acquiring) |-> ##[1:HOLD_MAX] o_acquiring;
  endproperty
  a_hold: assert property (p_hold) else $error("hold interval too long");

  property p_oe_normal;
    @(posedge i_mclk) disable iff (!i_resetn)
    !chain_lvl && enable_n_lvl ##1 !chain_lvl && enable_n_lvl |-> !o_result_serial_oe;
  endproperty
  a_oe_normal: assert property (p_oe_normal) else $error("output not disabled");

  property p_oe_chain;
    @(posedge i_mclk) disable iff (!i_resetn)
    chain_lvl |=> o_result_serial_oe;
  endproperty
  a_oe_chain: assert property (p_oe_chain) else $error("chain mode output off");

  property p_dgc;
    @(posedge i_mclk) disable iff (!i_resetn)
    conv_word.valid && gain_compression && code_hold == 18'h04000
      |-> conv_word.data == 18'h05000;
  endproperty
  a_dgc: assert property (p_dgc) else $error("compression scale wrong");

  property p_no_dgc;
    @(posedge i_mclk) disable iff (!i_resetn)
    conv_word.valid && !gain_compression |-> conv_word.data == code_hold;
  endproperty
  a_no_dgc: assert property (p_no_dgc) else $error("uncompressed code altered");

  property p_sat;
    @(posedge i_mclk) disable iff (!i_resetn)
    conv_word.valid && gain_compression && code_hold == 18'h1FFFC
      |-> conv_word.data == CODE_MAX_POS;
  endproperty
  a_sat: assert property (p_sat) else $error("positive clip wrong");

  property p_publish;
    @(posedge i_mclk) disable iff (!i_resetn)
    $fell(o_busy) |-> tx_word == last_push && tx_pending;
  endproperty
  a_publish: assert property (p_publish) else $error("result not published");

  property p_msb_first;
    @(posedge i_sck) disable iff (!sck_rstn)
      sck_load |=> o_result_serial_out == $past(tx_word[17])
      ##1 o_result_serial_out == $past(tx_word[16], 2);
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("bit order wrong");

  property p_chain_pass;
    @(posedge i_sck) disable iff (!sck_rstn)
      shift_cnt == SHIFT_CNT_WIDTH'(19) |-> o_result_serial_out == $past(chain_bit, 19);
  endproperty
  a_chain_pass: assert property (p_chain_pass) else $error("chained bit lost");

  c_conversion: cover property (@(posedge i_mclk) disable iff (!i_resetn) $fell(o_busy));
  c_stale: cover property (@(posedge i_mclk) disable iff (!i_resetn) start && tx_pending);
  c_chain: cover property (@(posedge i_sck) disable iff (!sck_rstn)
    shift_cnt == SHIFT_CNT_WIDTH'(19));
  c_dgc: cover property (@(posedge i_mclk) disable iff (!i_resetn)
    conv_word.valid && gain_compression);

endmodule : adc_convert_readout
`default_nettype wire

// ===== test/host_model.sv
// Host model: pulses convert, waits on busy, clocks the result out.
// Assumes the bench calls its tasks; sck stands still outside frames.
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input wire logic i_mclk,
  input wire logic i_busy,
  input wire logic i_result_serial_out,
  output logic o_convert_start,
  output logic o_sck,
  output logic o_enable_or_chain_input
);
  initial begin
    o_convert_start = 1'b0;
    o_sck = 1'b0;
    o_enable_or_chain_input = 1'b1;
  end

  // The sck domain leaves reset only on sck edges
  task automatic reset_pulses();
    repeat (4) begin
      #6 o_sck = 1'b1;
      #6 o_sck = 1'b0;
    end
  endtask : reset_pulses

  task automatic run_frame(input logic chain, input int nbits, input logic [35:0] chain_bits,
      output logic [35:0] got, output int rise_lat, output int busy_len);
    int n;
    int half;
    got = '0;
    rise_lat = 0;
    busy_len = 0;
    // Chain mode needs the slower clock
    half = chain ? 7 : 6;
    @(negedge i_mclk);
    o_enable_or_chain_input = chain ? chain_bits[35] : 1'b0;
    o_convert_start = 1'b1;
    while (!i_busy && rise_lat < 12) begin
      @(posedge i_mclk);
      rise_lat++;
    end
    @(negedge i_mclk);
    o_convert_start = 1'b0;
    // Sck held idle for the whole conversion
    while (i_busy && busy_len < 300) begin
      @(posedge i_mclk);
      busy_len++;
    end
    @(negedge i_mclk);
    for (n = 0; n < nbits; n++) begin
      if (chain) o_enable_or_chain_input = chain_bits[35-n];
      #(half) o_sck = 1'b1;
      #(half) o_sck = 1'b0;
      got[35-n] = i_result_serial_out;
    end
    // Released chain line shows the inverse of its last bit
    o_enable_or_chain_input = chain ? ~chain_bits[0] : 1'b1;
  endtask : run_frame
endmodule : host_model
`default_nettype wire

// ===== test/sar_adc_convert_and_serial_readout_tb.sv
// Self-checking bench for the converter control and serial readout.
// Assumes the host model on the far side and the package constants.
`timescale 1ns/100ps
`default_nettype none
module sar_adc_convert_and_serial_readout_tb;
  import adc_pkg::*;
  logic i_mclk, i_resetn, i_sck, i_convert_start, i_chain_mode;
  logic i_enable_or_chain_input, i_gain_compress_select;
  logic [17:0] i_sample_code;
  logic o_busy, o_power_down, o_acquiring, o_result_serial_out, o_result_serial_oe;
  int n_errors = 0;
  int samples_checked = 0;
  int hold_cnt = 0;
  int overlap_cnt = 0;
  logic [35:0] exp_q [$];
  logic [17:0] edge_codes [5] = '{18'h1FFFF, 18'h20000, 18'h00000, 18'h3FFFF, 18'h15555};
  logic [17:0] comp_codes [5] = '{18'h04000, 18'h1FFFC, 18'h20000, 18'h3FFFC, 18'h19998};

  adc_convert_readout #(.WIDTH(RESULT_WIDTH), .CONV_CNT(CONV_CYCLES),
      .HOLD_CNT(HOLD_CYCLES)) dut_u (
    .i_mclk(i_mclk), .i_resetn(i_resetn), .i_sck(i_sck),
    .i_convert_start(i_convert_start), .i_chain_mode(i_chain_mode),
    .i_enable_or_chain_input(i_enable_or_chain_input),
    .i_gain_compress_select(i_gain_compress_select), .i_sample_code(i_sample_code),
    .o_busy(o_busy), .o_power_down(o_power_down), .o_acquiring(o_acquiring),
    .o_result_serial_out(o_result_serial_out), .o_result_serial_oe(o_result_serial_oe));

  host_model host_u (
    .i_mclk(i_mclk), .i_busy(o_busy), .i_result_serial_out(o_result_serial_out),
    .o_convert_start(i_convert_start), .o_sck(i_sck),
    .o_enable_or_chain_input(i_enable_or_chain_input));

  initial begin
    i_mclk = 1'b0;
    forever #20 i_mclk = ~i_mclk;
  end

  // Hold length and busy/power-down overlap counted per frame
  always @(posedge i_mclk) begin
    if (!o_acquiring) hold_cnt++;
    if (o_busy && o_power_down) overlap_cnt++;
  end

  // Compression assumes codes with two clear low bits, so no rounding arises
  function automatic logic [17:0] ref_code(logic [17:0] s, logic gain_sel);
    int v;
    v = $signed(s);
    if (!gain_sel) v = (v * 5) / 4;
    if (v > 131071) v = 131071;
    if (v < -131072) v = -131072;
    return v[17:0];
  endfunction : ref_code

  task automatic check_bits(string name, logic [35:0] expv, logic [35:0] got);
    samples_checked++;
    if (got !== expv) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", name, expv, got);
    end
  endtask : check_bits

  task automatic check_range(string name, int v, int lo, int hi);
    samples_checked++;
    if (v < lo || v > hi) begin
      n_errors++;
      $display("wrong value %s expected %0d..%0d seen %0d", name, lo, hi, v);
    end
  endtask : check_range

  task automatic do_frame(logic [17:0] code, logic gain_sel, logic chain);
    logic [35:0] chain_bits, got, expv;
    int rise_lat, busy_len;
    chain_bits = {$urandom, 4'($urandom)};
    @(negedge i_mclk);
    i_sample_code = code;
    i_gain_compress_select = gain_sel;
    i_chain_mode = chain;
    repeat (6) @(negedge i_mclk);
    hold_cnt = 0;
    overlap_cnt = 0;
    // Model predicts the word at the convert edge, compared once it is read
    exp_q.push_back({ref_code(code, gain_sel), chain ? chain_bits[35:18] : 18'h00000});
    host_u.run_frame(chain, chain ? 36 : 18, chain_bits, got, rise_lat, busy_len);
    expv = exp_q.pop_front();
    if (!chain) got[17:0] = 18'h00000;
    check_bits("serial word", expv, got);
    check_bits("oe in readout", 36'h1, {35'h0, o_result_serial_oe});
    check_range("busy rise", rise_lat, 1, 7);
    check_range("busy length", busy_len, CONV_CYCLES, CONV_CYCLES + 6);
    check_range("hold cycles", hold_cnt, 1, HOLD_CYCLES);
    check_range("busy power overlap", overlap_cnt, 0, 0);
    repeat (8) @(negedge i_mclk);
    check_bits("oe after readout", {35'h0, chain}, {35'h0, o_result_serial_oe});
    // Spacing keeps the full conversion cycle
    repeat (30) @(negedge i_mclk);
  endtask : do_frame

  task automatic complete_run();
    if (n_errors == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : complete_run

  initial begin
    #500000;
    n_errors++;
    complete_run();
  end

  initial begin
    logic [17:0] s;
    logic g, c;
    logic [35:0] skip_got;
    int skip_lat, skip_len;
    i_resetn = 1'b0;
    i_sample_code = 18'h00000;
    i_gain_compress_select = 1'b1;
    i_chain_mode = 1'b0;
    void'($urandom(97));
    fork
      host_u.reset_pulses();
    join_none
    repeat (5) @(negedge i_mclk);
    i_resetn = 1'b1;
    // The sck side sees the release only on its own edges
    host_u.reset_pulses();
    foreach (edge_codes[i]) do_frame(edge_codes[i], 1'b1, 1'b0);
    foreach (comp_codes[i]) do_frame(comp_codes[i], 1'b0, 1'b0);
    // Unread result must give way to the next conversion
    @(negedge i_mclk);
    i_sample_code = 18'h0AAAA;
    host_u.run_frame(1'b0, 0, 36'h0, skip_got, skip_lat, skip_len);
    repeat (40) @(negedge i_mclk);
    do_frame(18'h12344, 1'b1, 1'b0);
    do_frame(18'h20001, 1'b1, 1'b1);
    repeat (12) begin
      g = 1'($urandom);
      c = 1'($urandom);
      s = 18'($urandom);
      if (!g) s[1:0] = 2'b00;
      do_frame(s, g, c);
    end
    complete_run();
  end
endmodule : sar_adc_convert_and_serial_readout_tb
`default_nettype wire
